// File: include/codec_cfg_pkg.sv
// Command codes, field layouts, reset values and carrier types for the codec register bank.
package codec_cfg_pkg;

  localparam int unsigned NUM_CH = 4;

  // Command bytes with the low bit cleared, except the two odd real-time codes; bit 0 set means read.
  localparam logic [7:0] CMD_RX_SLOT   = 8'h42;
  localparam logic [7:0] CMD_CLK_SLOT  = 8'h44;
  localparam logic [7:0] CMD_GLOBAL    = 8'h46;
  localparam logic [7:0] CMD_CH_ENABLE = 8'h4a;
  localparam logic [7:0] CMD_RT_READ   = 8'h4d;
  localparam logic [7:0] CMD_RT_CLEAR  = 8'h4f;
  localparam logic [7:0] CMD_GAIN      = 8'h50;
  localparam logic [7:0] CMD_LINE_IO   = 8'h52;

  localparam logic [7:0] RST_RX_SLOT_BASE = 8'h00;
  localparam logic [7:0] RST_CLK_SLOT     = 8'h00;
  localparam logic [7:0] RST_GLOBAL       = 8'h9a;
  localparam logic [7:0] RST_CH_ENABLE    = 8'h0f;
  localparam logic [7:0] RST_GAIN         = 8'h00;
  localparam logic [7:0] RST_LINE_IO      = 8'h00;

  // Receive slot register fields.
  localparam int unsigned RXS_HWY_BIT = 7;
  // Clock slot register fields.
  localparam int unsigned CS_DUAL_BIT = 7;
  localparam int unsigned CS_EDGE_BIT = 6;
  localparam int unsigned CS_RX_LSB   = 3;
  localparam int unsigned CS_TX_LSB   = 0;
  // Global configuration fields.
  localparam int unsigned GC_IRQ_BIT  = 7;
  localparam int unsigned GC_CHP_BIT  = 6;
  localparam int unsigned GC_SIG_BIT  = 5;
  localparam int unsigned GC_SRC_BIT  = 4;
  // Channel enable and mode fields.
  localparam int unsigned CE_RBE_BIT  = 6;
  localparam int unsigned CE_VM_BIT   = 5;
  localparam int unsigned CE_LPM_BIT  = 4;
  // Gain register fields.
  localparam int unsigned AG_TX_BIT   = 6;
  localparam int unsigned AG_RX_BIT   = 5;
  localparam logic [4:0] IMPEDANCE_SCALE_COEFF_LOOPBACK = 5'h10;
  localparam logic [4:0] IMPEDANCE_SCALE_COEFF_CUTOFF   = 5'h00;
  localparam logic [5:0] IMPEDANCE_SCALE_COEFF_OFFSET   = 6'h10;
  // Line I/O fields.
  localparam int unsigned LIO_MUXB_BIT = 5;

  // Chopper divider terminal counts and high-phase length, in 2048 kHz ticks.
  localparam logic [2:0] CHOP_LAST_DIV8 = 3'h7;
  localparam logic [2:0] CHOP_LAST_DIV7 = 3'h6;
  localparam logic [2:0] CHOP_HIGH_LEN  = 3'h4;

  // Master clock base rates in kHz.
  localparam logic [13:0] FREQ_1536 = 14'h0600;
  localparam logic [13:0] FREQ_1544 = 14'h0608;
  localparam logic [13:0] FREQ_2048 = 14'h0800;

  typedef enum logic [1:0] {
    ST_CMD  = 2'b01,
    ST_DATA = 2'b10
  } port_state_t;

  typedef struct packed {
    port_state_t           state;
    logic [7:0]            cmd;
    logic [3:0]            wr_mask;
    logic [3:0][7:0]       rx_slot;
    logic [7:0]            clk_slot;
    logic [7:0]            global_cfg;
    logic [7:0]            ch_enable;
    logic [3:0][7:0]       gain;
    logic [3:0][7:0]       line_io;
    logic                  irq_pending;
    logic [7:0]            rdata;
    logic                  rvalid;
    logic [2:0]            chop_cnt;
    logic                  chop_clk;
  } bank_state_t;

  typedef struct packed {
    logic                  use_pclk;
    logic                  e1_allowed;
    logic [13:0]           freq_khz;
    logic                  freq_reserved;
  } clock_cfg_t;

endpackage

// File: core/codec_cfg_regs.sv
// Command-addressed configuration register bank of a four-channel voice codec.
`timescale 1ns/100ps
module codec_cfg_regs #(
  parameter int unsigned CHANNELS = 4
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 host_strobe,
  input  wire logic [7:0]           host_wdata,
  output logic [7:0]                host_rdata,
  output logic                      host_rvalid,
  input  wire logic [3:0]           debounced_input_a,
  input  wire logic [3:0]           input_b,
  input  wire logic                 rt_change,
  input  wire logic [3:0]           chan_active,
  input  wire logic                 mu_law_select,
  input  wire logic                 e1_mux_enable,
  input  wire logic [3:0]           tx_highway_select,
  input  wire logic [3:0][4:0]      line_io_dir,
  input  wire logic                 clk2048_en,
  output logic                      irq_out,
  output logic                      irq_oe,
  output logic                      chopper_clk,
  output logic [3:0][6:0]           rx_time_slot,
  output logic [3:0]                rx_highway_select,
  output logic [3:0]                tx_on_highway_a,
  output logic [3:0]                tx_on_highway_b,
  output logic [2:0]                rx_clock_slot,
  output logic [2:0]                tx_clock_slot,
  output logic                      tx_launch_edge,
  output logic                      pcm_signaling_enable,
  output codec_cfg_pkg::clock_cfg_t clock_cfg,
  output logic                      robbed_bit_active,
  output logic [3:0]                analog_out_hold_ref,
  output logic [3:0]                analog_out_hiz,
  output logic                      low_power_state,
  output logic [3:0]                tx_analog_gain,
  output logic [3:0]                rx_analog_loss,
  output logic [3:0][5:0]           impedance_scale_gain,
  output logic [3:0]                scale_loopback,
  output logic [3:0]                scale_cutoff,
  output logic [3:0][4:0]           line_io_out,
  output logic [3:0][4:0]           line_io_oe,
  output logic [3:0]                muxed_output_b
);

  initial begin
    if (CHANNELS != codec_cfg_pkg::NUM_CH) begin
      $error("codec_cfg_regs serves exactly four channels");
    end
  end

  codec_cfg_pkg::bank_state_t s_r;
  codec_cfg_pkg::bank_state_t s_nxt;

  logic [7:0] cmd_even;
  logic       is_read;
  logic       any_enabled;
  logic [1:0] first_ch;
  logic [3:0] ch_mask;
  logic [7:0] rt_byte;

  assign ch_mask     = s_r.ch_enable[3:0];
  assign any_enabled = |ch_mask;
  assign cmd_even    = {host_wdata[7:1], 1'b0};
  assign is_read     = host_wdata[0];

  // Reads of a per-channel register answer from the lowest enabled channel.
  always_comb begin
    first_ch = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (ch_mask[i]) begin
        first_ch = 2'(i);
      end
    end
  end

  // Two bits per channel, channel one in the lowest pair.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rt_byte[2*i]   = debounced_input_a[i];
      rt_byte[2*i+1] = input_b[i];
    end
  end

  always_comb begin
    s_nxt        = s_r;
    s_nxt.rvalid = 1'b0;
    // An interrupt event in the clearing cycle keeps the flag set.
    if (rt_change) begin
      s_nxt.irq_pending = 1'b1;
    end
    unique case (s_r.state)
      codec_cfg_pkg::ST_CMD: begin
        if (host_strobe && !is_read) begin
          s_nxt.cmd     = cmd_even;
          s_nxt.wr_mask = 4'h0;
          unique case (cmd_even)
            codec_cfg_pkg::CMD_RX_SLOT,
            codec_cfg_pkg::CMD_GAIN,
            codec_cfg_pkg::CMD_LINE_IO: begin
              s_nxt.wr_mask = ch_mask;
              s_nxt.state   = codec_cfg_pkg::ST_DATA;
            end
            codec_cfg_pkg::CMD_CLK_SLOT: begin
              s_nxt.wr_mask = {3'b000, any_enabled};
              s_nxt.state   = codec_cfg_pkg::ST_DATA;
            end
            codec_cfg_pkg::CMD_GLOBAL,
            codec_cfg_pkg::CMD_CH_ENABLE: begin
              s_nxt.wr_mask = 4'h1;
              s_nxt.state   = codec_cfg_pkg::ST_DATA;
            end
            default: begin
            end
          endcase
        end else if (host_strobe) begin
          unique case (cmd_even)
            codec_cfg_pkg::CMD_RX_SLOT: begin
              s_nxt.rdata  = s_r.rx_slot[first_ch];
              s_nxt.rvalid = any_enabled;
            end
            codec_cfg_pkg::CMD_GAIN: begin
              s_nxt.rdata  = s_r.gain[first_ch];
              s_nxt.rvalid = any_enabled;
            end
            codec_cfg_pkg::CMD_LINE_IO: begin
              s_nxt.rdata  = s_r.line_io[first_ch];
              s_nxt.rvalid = any_enabled;
            end
            codec_cfg_pkg::CMD_CLK_SLOT: begin
              s_nxt.rdata  = s_r.clk_slot;
              s_nxt.rvalid = any_enabled;
            end
            codec_cfg_pkg::CMD_GLOBAL: begin
              s_nxt.rdata  = s_r.global_cfg;
              s_nxt.rvalid = 1'b1;
            end
            codec_cfg_pkg::CMD_CH_ENABLE: begin
              s_nxt.rdata  = s_r.ch_enable;
              s_nxt.rvalid = 1'b1;
            end
            // Both real-time codes are odd, so match them with their read bit cleared.
            codec_cfg_pkg::CMD_RT_READ & 8'hfe,
            codec_cfg_pkg::CMD_RT_CLEAR & 8'hfe: begin
              s_nxt.rdata  = rt_byte;
              s_nxt.rvalid = 1'b1;
              if (host_wdata[1] && !rt_change) begin
                s_nxt.irq_pending = 1'b0;
              end
            end
            default: begin
            end
          endcase
        end
      end
      codec_cfg_pkg::ST_DATA: begin
        if (host_strobe) begin
          s_nxt.state = codec_cfg_pkg::ST_CMD;
          unique case (s_r.cmd)
            codec_cfg_pkg::CMD_CLK_SLOT: begin
              if (s_r.wr_mask[0]) begin
                s_nxt.clk_slot = host_wdata;
              end
            end
            codec_cfg_pkg::CMD_GLOBAL: begin
              s_nxt.global_cfg = host_wdata;
            end
            codec_cfg_pkg::CMD_CH_ENABLE: begin
              s_nxt.ch_enable = host_wdata;
            end
            default: begin
              for (int i = 0; i < 4; i++) begin
                if (s_r.wr_mask[i]) begin
                  if (s_r.cmd == codec_cfg_pkg::CMD_RX_SLOT) begin
                    s_nxt.rx_slot[i] = host_wdata;
                  end
                  if (s_r.cmd == codec_cfg_pkg::CMD_GAIN) begin
                    s_nxt.gain[i] = host_wdata;
                  end
                  if (s_r.cmd == codec_cfg_pkg::CMD_LINE_IO) begin
                    s_nxt.line_io[i] = host_wdata;
                  end
                end
              end
            end
          endcase
        end
      end
      default: begin
        s_nxt.state = codec_cfg_pkg::ST_CMD;
      end
    endcase
    // The chopper runs from the 2048 kHz enable; divide by 8 or by 7.
    if (clk2048_en) begin
      if (s_r.chop_cnt == (s_r.global_cfg[codec_cfg_pkg::GC_CHP_BIT]
                           ? codec_cfg_pkg::CHOP_LAST_DIV7
                           : codec_cfg_pkg::CHOP_LAST_DIV8)) begin
        s_nxt.chop_cnt = 3'h0;
      end else begin
        s_nxt.chop_cnt = s_r.chop_cnt + 3'h1;
      end
      s_nxt.chop_clk = s_nxt.chop_cnt < codec_cfg_pkg::CHOP_HIGH_LEN;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r.state       <= codec_cfg_pkg::ST_CMD;
      s_r.cmd         <= 8'h00;
      s_r.wr_mask     <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        s_r.rx_slot[i] <= codec_cfg_pkg::RST_RX_SLOT_BASE + 8'(i);
        s_r.gain[i]    <= codec_cfg_pkg::RST_GAIN;
        s_r.line_io[i] <= codec_cfg_pkg::RST_LINE_IO;
      end
      s_r.clk_slot    <= codec_cfg_pkg::RST_CLK_SLOT;
      s_r.global_cfg  <= codec_cfg_pkg::RST_GLOBAL;
      s_r.ch_enable   <= codec_cfg_pkg::RST_CH_ENABLE;
      s_r.irq_pending <= 1'b0;
      s_r.rdata       <= 8'h00;
      s_r.rvalid      <= 1'b0;
      s_r.chop_cnt    <= 3'h0;
      s_r.chop_clk    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign host_rdata  = s_r.rdata;
  assign host_rvalid = s_r.rvalid;

  // Interrupt is active low; open-drain mode only pulls while pending.
  always_comb begin
    if (s_r.global_cfg[codec_cfg_pkg::GC_IRQ_BIT]) begin
      irq_out = 1'b0;
      irq_oe  = s_r.irq_pending;
    end else begin
      irq_out = ~s_r.irq_pending;
      irq_oe  = 1'b1;
    end
  end

  assign chopper_clk          = s_r.chop_clk;
  assign rx_clock_slot        = s_r.clk_slot[codec_cfg_pkg::CS_RX_LSB +: 3];
  assign tx_clock_slot        = s_r.clk_slot[codec_cfg_pkg::CS_TX_LSB +: 3];
  assign tx_launch_edge       = s_r.clk_slot[codec_cfg_pkg::CS_EDGE_BIT];
  assign pcm_signaling_enable = s_r.global_cfg[codec_cfg_pkg::GC_SIG_BIT];
  assign robbed_bit_active    = s_r.ch_enable[codec_cfg_pkg::CE_RBE_BIT]
                                & mu_law_select;
  assign low_power_state      = s_r.ch_enable[codec_cfg_pkg::CE_LPM_BIT]
                                & ~(|chan_active);

  // Master clock source and frequency decode.
  always_comb begin
    logic [1:0] base_sel;
    logic [1:0] mult_sel;
    logic [13:0] base;
    base_sel = s_r.global_cfg[1:0];
    mult_sel = s_r.global_cfg[3:2];
    base     = codec_cfg_pkg::FREQ_1536;
    clock_cfg.use_pclk   = s_r.global_cfg[codec_cfg_pkg::GC_SRC_BIT];
    clock_cfg.e1_allowed = s_r.global_cfg[codec_cfg_pkg::GC_SRC_BIT]
                           & e1_mux_enable;
    unique case (base_sel)
      2'b00:   base = codec_cfg_pkg::FREQ_1536;
      2'b01:   base = codec_cfg_pkg::FREQ_1544;
      2'b10:   base = codec_cfg_pkg::FREQ_2048;
      default: base = 14'h0000;
    endcase
    clock_cfg.freq_khz      = (base << mult_sel);
    clock_cfg.freq_reserved = (base_sel == 2'b11) | (mult_sel == 2'b11);
    if (clock_cfg.freq_reserved) begin
      clock_cfg.freq_khz = 14'h0000;
    end
  end

  // Per-channel decode of the stored settings.
  for (genvar c = 0; c < 4; c++) begin : g_ch
    logic       dual;
    logic [4:0] impedance_scale_coeff;
    assign dual = s_r.clk_slot[codec_cfg_pkg::CS_DUAL_BIT];
    assign impedance_scale_coeff = s_r.gain[c][4:0];
    assign rx_time_slot[c]      = s_r.rx_slot[c][6:0];
    assign rx_highway_select[c] = s_r.rx_slot[c][codec_cfg_pkg::RXS_HWY_BIT];
    assign tx_on_highway_a[c]   = dual | ~tx_highway_select[c];
    assign tx_on_highway_b[c]   = dual | tx_highway_select[c];
    assign analog_out_hold_ref[c] = ~chan_active[c]
                                    & ~s_r.ch_enable[codec_cfg_pkg::CE_VM_BIT];
    assign analog_out_hiz[c]    = ~chan_active[c]
                                  & s_r.ch_enable[codec_cfg_pkg::CE_VM_BIT];
    assign tx_analog_gain[c]    = s_r.gain[c][codec_cfg_pkg::AG_TX_BIT];
    assign rx_analog_loss[c]    = s_r.gain[c][codec_cfg_pkg::AG_RX_BIT];
    // Gain in sixteenths, two's complement.
    assign impedance_scale_gain[c] = {1'b0, impedance_scale_coeff} - codec_cfg_pkg::IMPEDANCE_SCALE_COEFF_OFFSET;
    assign scale_loopback[c]    = impedance_scale_coeff == codec_cfg_pkg::IMPEDANCE_SCALE_COEFF_LOOPBACK;
    assign scale_cutoff[c]      = impedance_scale_coeff == codec_cfg_pkg::IMPEDANCE_SCALE_COEFF_CUTOFF;
    assign line_io_out[c]       = s_r.line_io[c][4:0] & line_io_dir[c];
    assign line_io_oe[c]        = line_io_dir[c];
    assign muxed_output_b[c]    = s_r.line_io[c][codec_cfg_pkg::LIO_MUXB_BIT]
                                  & clock_cfg.e1_allowed;
  end

endmodule

// File: sim/codec_cfg_regs_assertions.sv
// Port-level assertions for the codec configuration register bank.
`timescale 1ns/100ps
module codec_cfg_regs_assertions #(
  parameter int unsigned CHANNELS = 4
) (
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire logic                       host_strobe,
  input wire logic [7:0]                 host_wdata,
  input wire logic [7:0]                 host_rdata,
  input wire logic                       host_rvalid,
  input wire logic [3:0]                 debounced_input_a,
  input wire logic [3:0]                 input_b,
  input wire logic                       rt_change,
  input wire logic [3:0]                 chan_active,
  input wire logic                       mu_law_select,
  input wire logic [3:0]                 tx_highway_select,
  input wire logic [3:0][4:0]            line_io_dir,
  input wire logic                       irq_out,
  input wire logic                       irq_oe,
  input wire logic [3:0][6:0]            rx_time_slot,
  input wire logic [3:0]                 tx_on_highway_a,
  input wire logic [3:0]                 tx_on_highway_b,
  input wire codec_cfg_pkg::clock_cfg_t  clock_cfg,
  input wire logic                       robbed_bit_active,
  input wire logic [3:0]                 analog_out_hold_ref,
  input wire logic [3:0]                 analog_out_hiz,
  input wire logic                       low_power_state,
  input wire logic [3:0][4:0]            line_io_out,
  input wire logic [3:0][4:0]            line_io_oe,
  input wire logic [3:0]                 muxed_output_b
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic       pend_r;
  logic [7:0] rt_byte;
  wire        cmd_ok = host_strobe && !pend_r;
  // Pending shows as low pin driven in both pin modes, so one term covers both.
  wire        irq_on = irq_oe && !irq_out;
  always_comb begin
    for (int c = 0; c < 4; c++) rt_byte[2*c +: 2] = {input_b[c], debounced_input_a[c]};
  end
  // Tracks the data phase so that data bytes are not mistaken for commands.
  always_ff @(posedge ref_clk) begin
    if (rst) pend_r <= 1'b0;
    else if (host_strobe) pend_r <= !pend_r && host_wdata inside {8'h42, 8'h44, 8'h46,
                                                                  8'h4a, 8'h50, 8'h52};
  end
  chk_read_answer: assert property (
    cmd_ok && host_wdata inside {8'h47, 8'h4b, 8'h4d, 8'h4f} |=> host_rvalid)
    else $error("global read not answered");
  chk_rvalid_cause: assert property (
    host_rvalid |-> $past(cmd_ok && host_wdata[0])) else $error("unrequested read answer");
  chk_rt_data: assert property (
    cmd_ok && host_wdata inside {8'h4d, 8'h4f} |=> host_rdata == $past(rt_byte))
    else $error("real-time byte wrong");
  chk_irq_set: assert property (rt_change |=> irq_on) else $error("irq not raised");
  chk_irq_clear: assert property (
    cmd_ok && host_wdata == 8'h4f && !rt_change |=> !irq_on) else $error("irq not cleared");
  chk_irq_keep: assert property (
    irq_on && !(cmd_ok && host_wdata == 8'h4f) |=> irq_on) else $error("irq lost");
  chk_tx_highway: assert property (
    (tx_on_highway_a | tx_on_highway_b) == 4'hf && ((tx_on_highway_a ^ tx_on_highway_b)
    & (tx_on_highway_b ^ tx_highway_select)) == 4'h0) else $error("transmit highway wrong");
  chk_low_power: assert property (
    low_power_state |-> chan_active == 4'h0) else $error("low power with active channel");
  chk_robbed_bit: assert property (
    robbed_bit_active |-> mu_law_select) else $error("robbed bit without mu-law");
  chk_idle_out: assert property (
    (analog_out_hold_ref | analog_out_hiz) == ~chan_active
    && (analog_out_hold_ref & analog_out_hiz) == 4'h0) else $error("idle output wrong");
  chk_line_io: assert property (
    line_io_oe == line_io_dir && (line_io_out & ~line_io_dir) == '0)
    else $error("line io drives an input");
  chk_muxed_b: assert property (
    muxed_output_b != 4'h0 |-> clock_cfg.e1_allowed && clock_cfg.use_pclk)
    else $error("muxed bit without e1 mode");
  chk_reset_slots: assert property (disable iff (1'b0)
    rst |=> rx_time_slot == {7'h03, 7'h02, 7'h01, 7'h00}) else $error("slot reset wrong");
  cover property (cmd_ok && host_wdata == 8'h4f && irq_on);
  cover property (rt_change);
  cover property (low_power_state);
endmodule
bind codec_cfg_regs codec_cfg_regs_assertions #(.CHANNELS(CHANNELS)) i_chk (.*);

// File: sim/host_port_model.sv
// Host model that sends command and data bytes on the byte-wide command port.
`timescale 1ns/100ps
module host_port_model (
  input  wire logic       ref_clk,
  output logic            host_strobe,
  output logic [7:0]      host_wdata,
  input  wire logic [7:0] host_rdata,
  input  wire logic       host_rvalid
);
  initial begin
    host_strobe = 1'b0;
    host_wdata  = 8'h00;
  end
  // Command and data go back to back; when idle the byte lines carry the inverse of the
  // last byte, so a design that samples them without the strobe is caught.
  task automatic wr(input logic [7:0] cmd, input logic [7:0] x);
    @(negedge ref_clk);
    host_strobe = 1'b1;
    host_wdata  = {cmd[7:1], 1'b0};
    @(negedge ref_clk);
    host_wdata  = x;
    @(negedge ref_clk);
    host_strobe = 1'b0;
    host_wdata  = ~x;
  endtask
  task automatic rd(input logic [7:0] cmd, output logic v, output logic [7:0] x);
    @(negedge ref_clk);
    host_strobe = 1'b1;
    host_wdata  = cmd | 8'h01;
    @(negedge ref_clk);
    host_strobe = 1'b0;
    host_wdata  = ~host_wdata;
    v = host_rvalid;
    x = host_rdata;
  endtask
endmodule

// File: sim/codec_cfg_regs_tb.sv
// Self-checking bench for the codec configuration register bank.
`timescale 1ns/100ps
module codec_cfg_regs_tb;
  typedef struct packed {
    logic       wr;
    logic       ev;
    logic [7:0] cmd;
    logic [7:0] wd;
    logic [7:0] exp;
  } row_t;
  logic ref_clk, rst, host_strobe, host_rvalid, rt_change, mu_law_select, e1_mux_enable;
  logic clk2048_en, irq_out, irq_oe, chopper_clk, tx_launch_edge, pcm_signaling_enable, v;
  logic robbed_bit_active, low_power_state;
  logic [7:0] host_wdata, host_rdata, d;
  logic [3:0] debounced_input_a, input_b, chan_active, tx_highway_select, rx_highway_select;
  logic [3:0] tx_on_highway_a, tx_on_highway_b, analog_out_hold_ref, analog_out_hiz;
  logic [3:0] tx_analog_gain, rx_analog_loss, scale_loopback, scale_cutoff, muxed_output_b;
  logic [3:0][4:0] line_io_dir, line_io_out, line_io_oe;
  logic [3:0][6:0] rx_time_slot;
  logic [3:0][5:0] impedance_scale_gain;
  logic [2:0] rx_clock_slot, tx_clock_slot;
  codec_cfg_pkg::clock_cfg_t clock_cfg;
  int err_count, n_tests, i, k;
  row_t rows [13] = '{
    '{1'h0, 1'h1, 8'h43, 8'h00, 8'h00}, '{1'h0, 1'h1, 8'h45, 8'h00, 8'h00},
    '{1'h0, 1'h1, 8'h47, 8'h00, 8'h9a}, '{1'h0, 1'h1, 8'h4b, 8'h00, 8'h0f},
    '{1'h0, 1'h1, 8'h51, 8'h00, 8'h00}, '{1'h0, 1'h1, 8'h53, 8'h00, 8'h00},
    '{1'h0, 1'h1, 8'h4d, 8'h00, 8'h6c}, '{1'h0, 1'h0, 8'h49, 8'h00, 8'h00},
    '{1'h1, 1'h1, 8'h42, 8'ha5, 8'ha5}, '{1'h1, 1'h1, 8'h44, 8'hdb, 8'hdb},
    '{1'h1, 1'h1, 8'h50, 8'h5f, 8'h5f}, '{1'h1, 1'h1, 8'h52, 8'h2a, 8'h2a},
    '{1'h1, 1'h1, 8'h46, 8'h1a, 8'h1a}};
  codec_cfg_regs i_codec_cfg_regs (.*);
  host_port_model i_host_port_model (.*);
  always #2.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) clk2048_en <= ~clk2048_en;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] c, input logic [7:0] x);
    i_host_port_model.wr(c, x);
  endtask
  task automatic rreg(input logic [7:0] c);
    i_host_port_model.rd(c, v, d);
  endtask
  function automatic logic [14:0] freq_exp(input int s);
    logic [13:0] b;
    b = (s % 4 == 0) ? 14'h0600 : (s % 4 == 1) ? 14'h0608 : 14'h0800;
    if (s % 4 == 3 || s >= 12) return 15'h0001;
    return {b << (s / 4), 1'b0};
  endfunction
  // Takes the last two rising edges in a fixed window, so a stalled divider fails the compare.
  task automatic chop_period(input logic [31:0] exp);
    logic p;
    int   r0, r1;
    p = chopper_clk;
    r0 = -1;
    r1 = -1;
    for (i = 0; i < 64; i++) begin
      @(negedge ref_clk);
      if (chopper_clk === 1'b1 && p === 1'b0) begin
        r0 = r1;
        r1 = i;
      end
      p = chopper_clk;
    end
    chk(r1 - r0, exp, "chopper period");
  endtask
  task automatic irq_round(input logic [7:0] g, input logic [1:0] idle);
    wreg(8'h46, g);
    rt_change = 1'b1;
    @(negedge ref_clk);
    rt_change = 1'b0;
    chk({irq_oe, irq_out}, 2'h2, "irq raised");
    rreg(8'h4d);
    chk({v, irq_oe, irq_out}, 3'h6, "irq kept");
    rreg(8'h4f);
    chk({v, irq_oe, irq_out}, {1'b1, idle}, "irq cleared");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    {ref_clk, clk2048_en, rt_change, mu_law_select, err_count, n_tests} = '0;
    {rst, e1_mux_enable} = 2'h3;
    {debounced_input_a, input_b, chan_active, tx_highway_select} = 16'ha600;
    line_io_dir = {4{5'h07}};
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    chk({irq_oe, irq_out, rx_time_slot}, {2'h0, 7'h03, 7'h02, 7'h01, 7'h00}, "reset");
    for (k = 0; k < 13; k++) begin
      if (rows[k].wr) wreg(rows[k].cmd, rows[k].wd);
      rreg(rows[k].cmd);
      chk(v, rows[k].ev, "answer");
      if (rows[k].ev) chk(d, rows[k].exp, "read byte");
    end
    chk(rx_time_slot, {4{7'h25}}, "slot");
    chk(rx_highway_select, 4'hf, "rx highway");
    chk({rx_clock_slot, tx_clock_slot, tx_launch_edge}, 7'h37, "clock slot");
    chk({tx_on_highway_a, tx_on_highway_b}, 8'hff, "dual highway");
    chk({tx_analog_gain, rx_analog_loss, impedance_scale_gain}, {8'hf0, {4{6'h0f}}}, "gain");
    chk({irq_oe, irq_out, pcm_signaling_enable, clock_cfg}, {3'h6, 2'h3, 14'h2000, 1'b0}, "cfg");
    chk(line_io_out, {4{5'h02}}, "line io");
    chk(muxed_output_b, 4'hf, "muxed bit");
    $display("test rows done");
    for (k = 0; k < 16; k++) begin
      wreg(8'h46, {4'h1, k[3:0]});
      chk({clock_cfg.freq_khz, clock_cfg.freq_reserved}, freq_exp(k), "freq");
    end
    wreg(8'h46, 8'h1a);
    chop_period(32'h10);
    wreg(8'h46, 8'h5a);
    chop_period(32'h0e);
    wreg(8'h46, 8'h0a);
    chk({clock_cfg.use_pclk, clock_cfg.e1_allowed, muxed_output_b}, 6'h00, "mclk");
    wreg(8'h46, 8'h3a);
    chk(pcm_signaling_enable, 1'b1, "signalling");
    $display("test global done");
    irq_round(8'h1a, 2'h3);
    irq_round(8'h9a, 2'h0);
    $display("test irq done");
    wreg(8'h4a, 8'h00);
    rreg(8'h45);
    chk(v, 1'b0, "clock slot refused");
    wreg(8'h44, 8'h00);
    rreg(8'h47);
    chk({v, d}, 9'h19a, "global open");
    rreg(8'h4d);
    chk(v, 1'b1, "rt open");
    chk(tx_launch_edge, 1'b1, "clock slot kept");
    wreg(8'h4a, 8'h72);
    wreg(8'h42, 8'h11);
    chk({rx_time_slot, rx_highway_select}, {7'h25, 7'h25, 7'h11, 7'h25, 4'hd}, "ch2");
    mu_law_select = 1'b1;
    chan_active = 4'h3;
    @(negedge ref_clk);
    chk({robbed_bit_active, low_power_state, analog_out_hiz, analog_out_hold_ref}, 10'h2c0, "mode");
    mu_law_select = 1'b0;
    chan_active = 4'h0;
    wreg(8'h4a, 8'h52);
    chk({robbed_bit_active, low_power_state, analog_out_hiz, analog_out_hold_ref}, 10'h10f, "mode");
    wreg(8'h50, 8'h70);
    chk({tx_analog_gain, rx_analog_loss, scale_loopback, scale_cutoff}, 16'hf220, "loop");
    wreg(8'h50, 8'h01);
    chk({tx_analog_gain, rx_analog_loss, impedance_scale_gain[1]}, {8'hd0, 6'h31}, "scale");
    wreg(8'h50, 8'h00);
    chk(scale_cutoff, 4'h2, "cutoff");
    wreg(8'h4a, 8'h0f);
    tx_highway_select = 4'h5;
    wreg(8'h44, 8'h00);
    chk({tx_on_highway_a, tx_on_highway_b, tx_launch_edge}, 9'h14a, "highway select");
    $display("test channel enable done");
    report_and_stop();
  end
endmodule
